/* File: verilog/aes_params.svh */
// constants for the address and exception sequencer
`ifndef AES_PARAMS_SVH
`define AES_PARAMS_SVH
// ------------------------------------------------------------
// vectors and fixed values
// ------------------------------------------------------------
`define AES_VEC_RESET   16'hFFFE
`define AES_VEC_SOFT    16'hFFFC
`define AES_VEC_IRQ_TOP 16'hFFFA
`define AES_DIRECT_HI   8'h00
`define AES_INC         16'h0001
`define AES_IMASK_BIT   3
`define AES_STACK_LAST  3'h4
`define AES_STACK_LEN   16'h0005
`define AES_FILL_LEN    16'h0003
`define AES_IRQ_NUM     8
`endif

/* File: verilog/aes_pkg.sv */
// types shared by the sequencer and its address calculator
package aes_pkg;
   typedef enum logic [3:0] {
      AM_DIR   = 4'h0,
      AM_LONG  = 4'h1,
      AM_IDX   = 4'h2,
      AM_IXP   = 4'h3,
      AM_IDB   = 4'h4,
      AM_IX1P  = 4'h5,
      AM_IDW   = 4'h6,
      AM_SPB   = 4'h7,
      AM_SPW   = 4'h8
   } aes_mode_e;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_RSTH = 4'h1,
      S_VHI  = 4'h2,
      S_VLO  = 4'h3,
      S_FREE = 4'h4,
      S_Q1   = 4'h5,
      S_Q2   = 4'h6,
      S_Q3   = 4'h7,
      S_STK  = 4'h8,
      S_EB1  = 4'h9,
      S_EB2  = 4'hA,
      S_EADR = 4'hB,
      S_EOP  = 4'hC,
      S_WAIT = 4'hD,
      S_STOP = 4'hE,
      S_BDM  = 4'hF
   } aes_state_e;

   typedef struct packed {
      aes_state_e  st;
      logic [2:0]  cnt;
      aes_mode_e   mode;
      logic        inc_ok;
      logic [7:0]  b_hi;
      logic [7:0]  b_lo;
      logic [15:0] vec;
      logic        bdm_armed;
      logic [15:0] bus_addr;
      logic        bus_rd;
      logic        bus_wr;
      logic [7:0]  bus_wdata;
      logic [15:0] ea;
      logic [7:0]  operand;
      logic        ea_done;
      logic        ea_fault;
      logic [15:0] hx_new;
      logic        hx_load;
      logic [15:0] sp_new;
      logic        sp_load;
      logic        set_imask;
      logic        clr_imask;
      logic [15:0] pc_new;
      logic        pc_load;
      logic        seq_done;
      logic        clk_en;
      logic        in_bdm;
      logic        osc_keep;
      logic        busy;
   } aes_st_s;
endpackage

/* File: verilog/aes_ea_if.sv */
// carrier between the sequencer and the address calculator
`timescale 1ns/10ps
interface aes_ea_if;
   aes_pkg::aes_mode_e mode;
   logic [15:0]        hx;
   logic [15:0]        sp;
   logic [15:0]        ofs;
   logic [15:0]        ea;
   logic [15:0]        hx_inc;
   modport calc (input mode, input hx, input sp, input ofs, output ea, output hx_inc);
   modport seq  (output mode, output hx, output sp, output ofs, input ea, input hx_inc);
endinterface

/* File: verilog/aes_ea_calc.sv */
// effective address and index increment arithmetic
`timescale 1ns/10ps
`include "aes_params.svh"
module aes_ea_calc (
   aes_ea_if.calc eif
);
   // ------------------------------------------------------------
   // address forming, all sums wrap at 16 bits
   // ------------------------------------------------------------
   always_comb begin
      unique case (eif.mode)
         aes_pkg::AM_DIR:  eif.ea = {`AES_DIRECT_HI, eif.ofs[7:0]};
         aes_pkg::AM_LONG: eif.ea = eif.ofs;
         aes_pkg::AM_IDX,
         aes_pkg::AM_IXP:  eif.ea = eif.hx;
         aes_pkg::AM_IDB,
         aes_pkg::AM_IX1P: eif.ea = eif.hx + {8'h00, eif.ofs[7:0]};
         aes_pkg::AM_IDW:  eif.ea = eif.hx + eif.ofs;
         aes_pkg::AM_SPB:  eif.ea = eif.sp + {8'h00, eif.ofs[7:0]};
         aes_pkg::AM_SPW:  eif.ea = eif.sp + eif.ofs;
         default:          eif.ea = 16'h0000;
      endcase
   end

   // carry out of bit 15 is dropped
   assign eif.hx_inc = eif.hx + `AES_INC;
endmodule // aes_ea_calc

/* File: verilog/aes_seq.sv */
// operand address and special operation sequencer
`timescale 1ns/10ps
`include "aes_params.svh"
module aes_seq (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_ce,
   // reset sources
   input  wire logic        i_reset_event,
   input  wire logic        i_reset_done,
   input  wire logic        i_bdm_strap,
   // core state and requests
   input  wire logic [15:0] i_pc,
   input  wire logic [15:0] i_hx,
   input  wire logic [15:0] i_sp,
   input  wire logic [7:0]  i_a,
   input  wire logic [7:0]  i_cond_codes,
   input  wire logic        i_boundary,
   input  wire logic        i_ea_req,
   input  wire logic [3:0]  i_ea_mode,
   input  wire logic        i_op_move,
   input  wire logic        i_op_compare_branch_if_equal,
   input  wire logic        i_soft_int,
   input  wire logic        i_wait,
   input  wire logic        i_stop,
   input  wire logic        i_brk_dbg,
   // interrupt sources and stop wake
   input  wire logic [7:0]  i_irq_pend,
   input  wire logic        i_stop_wake,
   // debug host
   input  wire logic        i_dbg_cmd,
   input  wire logic        i_dbg_resume,
   input  wire logic        i_dbg_enable,
   // memory bus
   input  wire logic [7:0]  i_bus_rdata,
   output logic [15:0]      o_bus_addr,
   output logic             o_bus_rd,
   output logic             o_bus_wr,
   output logic [7:0]       o_bus_wdata,
   // answers to the core
   output logic [15:0]      o_ea_addr,
   output logic [7:0]       o_operand,
   output logic             o_ea_done,
   output logic             o_ea_fault,
   output logic [15:0]      o_hx_new,
   output logic             o_hx_load,
   output logic [15:0]      o_sp_new,
   output logic             o_sp_load,
   output logic             o_set_imask,
   output logic             o_clr_imask,
   output logic [15:0]      o_pc_new,
   output logic             o_pc_load,
   output logic             o_seq_done,
   output logic             o_busy,
   // clocks and debug status
   output logic             o_cpu_clk_en,
   output logic             o_in_bdm,
   output logic             o_osc_keep
);
   aes_pkg::aes_st_s r;
   aes_pkg::aes_st_s next_r;
   aes_pkg::aes_st_s rst_val;
   aes_ea_if eif ();
   logic             irq_any;
   logic [15:0]      irq_vec;
   logic             dbg_on;

   aes_ea_calc u_calc (
      .eif (eif.calc)
   );

   assign eif.mode = r.mode;
   assign eif.hx   = i_hx;
   assign eif.sp   = i_sp;
   assign eif.ofs  = {r.b_hi, r.b_lo};
   assign dbg_on   = i_dbg_enable | r.bdm_armed;

   // ------------------------------------------------------------
   // priority pick: lowest index wins
   // ------------------------------------------------------------
   always_comb begin
      irq_any = 1'b0;
      irq_vec = `AES_VEC_IRQ_TOP;
      for (int i = `AES_IRQ_NUM - 1; i >= 0; i--) begin
         if (i_irq_pend[i]) begin
            irq_any = 1'b1;
            irq_vec = `AES_VEC_IRQ_TOP - 16'(2 * i);
         end
      end
   end

   // index high byte has no slot; service code saves it itself
   function automatic logic [7:0] stk_byte(input logic [2:0] idx);
      unique case (idx)
         3'h0:    stk_byte = i_pc[7:0];
         3'h1:    stk_byte = i_pc[15:8];
         3'h2:    stk_byte = i_hx[7:0];
         3'h3:    stk_byte = i_a;
         default: stk_byte = i_cond_codes;
      endcase
   endfunction

   function automatic logic [1:0] ofs_len(input aes_pkg::aes_mode_e m);
      unique case (m)
         aes_pkg::AM_LONG, aes_pkg::AM_IDW, aes_pkg::AM_SPW: ofs_len = 2'h2;
         aes_pkg::AM_IDX, aes_pkg::AM_IXP:                   ofs_len = 2'h0;
         default:                                           ofs_len = 2'h1;
      endcase
   endfunction

   always_comb begin
      rst_val        = '0;
      rst_val.st     = aes_pkg::S_RSTH;
      rst_val.clk_en = 1'b1;
      rst_val.busy   = 1'b1;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_r           = r;
      next_r.bus_rd    = 1'b0;
      next_r.bus_wr    = 1'b0;
      next_r.ea_done   = 1'b0;
      next_r.hx_load   = 1'b0;
      next_r.sp_load   = 1'b0;
      next_r.set_imask = 1'b0;
      next_r.clr_imask = 1'b0;
      next_r.pc_load   = 1'b0;
      next_r.seq_done  = 1'b0;
      next_r.osc_keep  = (r.st == aes_pkg::S_STOP) & dbg_on;
      if (i_reset_event) begin
         // no instruction boundary wait
         next_r           = rst_val;
         next_r.bdm_armed = r.bdm_armed;
      end else begin
         unique case (r.st)
            aes_pkg::S_RSTH: begin
               if (i_reset_done) begin
                  next_r.bdm_armed = i_bdm_strap;
                  next_r.vec       = `AES_VEC_RESET;
                  next_r.st        = aes_pkg::S_VHI;
                  next_r.bus_addr  = `AES_VEC_RESET;
                  next_r.bus_rd    = 1'b1;
               end
            end
            aes_pkg::S_IDLE: begin
               if (i_brk_dbg) begin
                  next_r.st     = aes_pkg::S_BDM;
                  next_r.in_bdm = 1'b1;
               end else if (i_soft_int
                            || (i_boundary && irq_any && !i_cond_codes[`AES_IMASK_BIT])) begin
                  // software interrupt bypasses the mask
                  next_r.vec       = i_soft_int ? `AES_VEC_SOFT : irq_vec;
                  next_r.st        = aes_pkg::S_STK;
                  next_r.cnt       = 3'h0;
                  next_r.bus_addr  = i_sp;
                  next_r.bus_wdata = stk_byte(3'h0);
                  next_r.bus_wr    = 1'b1;
               end else if (i_wait) begin
                  next_r.clr_imask = 1'b1;
                  next_r.clk_en    = 1'b0;
                  next_r.st        = aes_pkg::S_WAIT;
               end else if (i_stop) begin
                  next_r.clk_en = 1'b0;
                  next_r.st     = aes_pkg::S_STOP;
               end else if (i_ea_req) begin
                  next_r.mode   = aes_pkg::aes_mode_e'(i_ea_mode);
                  next_r.b_hi   = 8'h00;
                  next_r.b_lo   = 8'h00;
                  // post-increment only for the two allowed opcodes
                  next_r.inc_ok = (i_ea_mode == aes_pkg::AM_IXP && (i_op_move || i_op_compare_branch_if_equal))
                                | (i_ea_mode == aes_pkg::AM_IX1P && i_op_compare_branch_if_equal);
                  next_r.ea_fault = (i_ea_mode == aes_pkg::AM_IXP && !(i_op_move || i_op_compare_branch_if_equal))
                                  | (i_ea_mode == aes_pkg::AM_IX1P && !i_op_compare_branch_if_equal);
                  if (ofs_len(aes_pkg::aes_mode_e'(i_ea_mode)) == 2'h0) begin
                     next_r.st = aes_pkg::S_EADR;
                  end else begin
                     next_r.st       = aes_pkg::S_EB1;
                     next_r.bus_addr = i_pc;
                     next_r.bus_rd   = 1'b1;
                  end
               end
            end
            aes_pkg::S_STK: begin
               if (r.cnt == `AES_STACK_LAST) begin
                  next_r.set_imask = 1'b1;
                  next_r.sp_new    = i_sp - `AES_STACK_LEN;
                  next_r.sp_load   = 1'b1;
                  next_r.st        = aes_pkg::S_VHI;
                  next_r.bus_addr  = r.vec;
                  next_r.bus_rd    = 1'b1;
               end else begin
                  next_r.cnt       = r.cnt + 3'h1;
                  next_r.bus_addr  = i_sp - {13'h0000, r.cnt + 3'h1};
                  next_r.bus_wdata = stk_byte(r.cnt + 3'h1);
                  next_r.bus_wr    = 1'b1;
               end
            end
            aes_pkg::S_VHI: begin
               next_r.b_hi     = i_bus_rdata;
               next_r.st       = aes_pkg::S_VLO;
               next_r.bus_addr = r.vec + `AES_INC;
               next_r.bus_rd   = 1'b1;
            end
            aes_pkg::S_VLO: begin
               next_r.b_lo = i_bus_rdata;
               next_r.st   = aes_pkg::S_FREE;
            end
            aes_pkg::S_FREE: begin
               next_r.st       = aes_pkg::S_Q1;
               next_r.bus_addr = {r.b_hi, r.b_lo};
               next_r.bus_rd   = 1'b1;
            end
            aes_pkg::S_Q1, aes_pkg::S_Q2: begin
               next_r.st       = (r.st == aes_pkg::S_Q1) ? aes_pkg::S_Q2 : aes_pkg::S_Q3;
               next_r.bus_addr = r.bus_addr + `AES_INC;
               next_r.bus_rd   = 1'b1;
            end
            aes_pkg::S_Q3: begin
               next_r.pc_new   = {r.b_hi, r.b_lo} + `AES_FILL_LEN;
               next_r.pc_load  = 1'b1;
               next_r.seq_done = 1'b1;
               next_r.st       = r.bdm_armed ? aes_pkg::S_BDM : aes_pkg::S_IDLE;
               next_r.in_bdm   = r.bdm_armed;
            end
            aes_pkg::S_EB1: begin
               if (ofs_len(r.mode) == 2'h2) begin
                  next_r.b_hi     = i_bus_rdata;
                  next_r.st       = aes_pkg::S_EB2;
                  next_r.bus_addr = r.bus_addr + `AES_INC;
                  next_r.bus_rd   = 1'b1;
               end else begin
                  next_r.b_lo = i_bus_rdata;
                  next_r.st   = aes_pkg::S_EADR;
               end
            end
            aes_pkg::S_EB2: begin
               next_r.b_lo = i_bus_rdata;
               next_r.st   = aes_pkg::S_EADR;
            end
            aes_pkg::S_EADR: begin
               next_r.ea       = eif.ea;
               next_r.st       = aes_pkg::S_EOP;
               next_r.bus_addr = eif.ea;
               next_r.bus_rd   = 1'b1;
            end
            aes_pkg::S_EOP: begin
               next_r.operand = i_bus_rdata;
               next_r.ea_done = 1'b1;
               next_r.hx_new  = eif.hx_inc;
               next_r.hx_load = r.inc_ok;
               next_r.st      = aes_pkg::S_IDLE;
            end
            aes_pkg::S_WAIT: begin
               if (i_dbg_cmd) begin
                  next_r.clk_en = 1'b1;
                  next_r.in_bdm = 1'b1;
                  next_r.st     = aes_pkg::S_BDM;
               end else if (irq_any) begin
                  next_r.clk_en = 1'b1;
                  next_r.st     = aes_pkg::S_IDLE;
               end
            end
            aes_pkg::S_STOP: begin
               if (i_dbg_cmd && dbg_on) begin
                  next_r.clk_en = 1'b1;
                  next_r.in_bdm = 1'b1;
                  next_r.st     = aes_pkg::S_BDM;
               end else if (i_stop_wake) begin
                  next_r.clk_en = 1'b1;
                  next_r.st     = aes_pkg::S_IDLE;
               end
            end
            aes_pkg::S_BDM: begin
               if (i_dbg_resume) begin
                  next_r.in_bdm    = 1'b0;
                  next_r.bdm_armed = 1'b0;
                  next_r.st        = aes_pkg::S_IDLE;
               end
            end
         endcase
      end
      // busy kept in a flop so the output needs no gate
      next_r.busy = (next_r.st != aes_pkg::S_IDLE);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         r <= rst_val;
      end else if (i_ce) begin
         r <= next_r;
      end
   end

   assign o_bus_addr   = r.bus_addr;
   assign o_bus_rd     = r.bus_rd;
   assign o_bus_wr     = r.bus_wr;
   assign o_bus_wdata  = r.bus_wdata;
   assign o_ea_addr    = r.ea;
   assign o_operand    = r.operand;
   assign o_ea_done    = r.ea_done;
   assign o_ea_fault   = r.ea_fault;
   assign o_hx_new     = r.hx_new;
   assign o_hx_load    = r.hx_load;
   assign o_sp_new     = r.sp_new;
   assign o_sp_load    = r.sp_load;
   assign o_set_imask  = r.set_imask;
   assign o_clr_imask  = r.clr_imask;
   assign o_pc_new     = r.pc_new;
   assign o_pc_load    = r.pc_load;
   assign o_seq_done   = r.seq_done;
   assign o_busy       = r.busy;
   assign o_cpu_clk_en = r.clk_en;
   assign o_in_bdm     = r.in_bdm;
   assign o_osc_keep   = r.osc_keep;

   // ------------------------------------------------------------
   // checks, frozen cycles excluded
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b || !i_ce);

   property p_dir_page;
      o_ea_done && r.mode == aes_pkg::AM_DIR |-> o_ea_addr[15:8] == 8'h00;
   endproperty
   a_dir_page: assert property (p_dir_page) else $error("direct page high byte");

   property p_abort;
      i_reset_event |=> r.st == aes_pkg::S_RSTH && !o_bus_rd && !o_bus_wr;
   endproperty
   a_abort: assert property (p_abort) else $error("reset did not abort");

   sequence s_rst_vec;
      o_bus_rd && o_bus_addr == 16'hFFFE ##1 o_bus_rd && o_bus_addr == 16'hFFFF;
   endsequence
   property p_rst_vec;
      r.st == aes_pkg::S_RSTH && i_reset_done && !i_reset_event |=> s_rst_vec;
   endproperty
   a_rst_vec: assert property (p_rst_vec) else $error("reset vector fetch");

   property p_stk_first;
      r.st == aes_pkg::S_IDLE && !i_reset_event && !i_brk_dbg && i_soft_int
         |=> o_bus_wr && o_bus_addr == $past(i_sp) && o_bus_wdata == $past(i_pc[7:0]);
   endproperty
   a_stk_first: assert property (p_stk_first) else $error("first stacked byte");

   property p_mask;
      r.st == aes_pkg::S_IDLE && !i_soft_int && i_cond_codes[3] |=> r.st != aes_pkg::S_STK;
   endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt taken");

   sequence s_tail;
      ##1 !o_bus_rd ##1 o_bus_rd[*3] ##1 o_pc_load;
   endsequence
   property p_tail;
      r.st == aes_pkg::S_VLO && !i_reset_event |-> s_tail;
   endproperty
   a_tail: assert property (p_tail) else $error("vector tail order");

   property p_wait;
      r.st == aes_pkg::S_IDLE && !i_reset_event && i_wait && !i_brk_dbg && !i_soft_int
         && !(i_boundary && irq_any && !i_cond_codes[3]) |=> o_clr_imask && !o_cpu_clk_en;
   endproperty
   a_wait: assert property (p_wait) else $error("wait entry");

   property p_post_inc;
      o_hx_load |-> o_hx_new == i_hx + 16'h0001 && o_ea_done;
   endproperty
   a_post_inc: assert property (p_post_inc) else $error("post increment value");

   property p_osc;
      r.st == aes_pkg::S_STOP && dbg_on && !i_reset_event |=> o_osc_keep;
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator not kept");
endmodule // aes_seq

/* File: testbench/aes_mem_model.sv */
// behavioural memory on the far side of the sequencer bus
`timescale 1ns/10ps
module aes_mem_model (
   // clock
   input  wire logic        i_clk,
   // bus from the sequencer
   input  wire logic [15:0] i_addr,
   input  wire logic        i_rd,
   input  wire logic        i_wr,
   input  wire logic [7:0]  i_wdata,
   output logic [7:0]       o_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'h00;
   initial for (int a = 0; a < 65536; a++) mem[a] = a[7:0] ^ a[15:8];
   // idle bus shows the inverse so a stale byte never passes
   always_comb o_rdata = i_rd ? mem[i_addr] : ~last;
   always @(posedge i_clk) begin
      if (i_rd) last <= mem[i_addr];
      if (i_wr) mem[i_addr] <= i_wdata;
   end
endmodule // aes_mem_model

/* File: testbench/tb.sv */
// self-checking bench for the address and exception sequencer
`timescale 1ns/10ps
module tb;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic i_clk = 0, i_rst_b = 0, i_ce = 1, i_reset_event = 0, i_reset_done = 1;
   logic i_bdm_strap = 0, i_boundary = 0, i_ea_req = 0, i_op_move = 0, i_op_compare_branch_if_equal = 0;
   logic i_soft_int = 0, i_wait = 0, i_stop = 0, i_brk_dbg = 0, i_stop_wake = 0;
   logic i_dbg_cmd = 0, i_dbg_resume = 0, i_dbg_enable = 0;
   logic [15:0] i_pc = 16'h1000, i_hx = 16'h0000, i_sp = 16'h0300;
   logic [7:0]  i_a = 8'h00, i_cond_codes = 8'h08, i_irq_pend = 8'h00, i_bus_rdata;
   logic [3:0]  i_ea_mode = 4'h0;
   logic [15:0] o_bus_addr, o_ea_addr, o_hx_new, o_sp_new, o_pc_new, sp_seen;
   logic [7:0]  o_bus_wdata, o_operand;
   logic o_bus_rd, o_bus_wr, o_ea_done, o_ea_fault, o_hx_load, o_sp_load, o_set_imask;
   logic o_clr_imask, o_pc_load, o_seq_done, o_busy, o_cpu_clk_en, o_in_bdm, o_osc_keep;
   logic im_seen, clr_seen;
   int   mismatches = 0, checks = 0;
   aes_seq DUT (.*);
   aes_mem_model u_mem (.i_clk(i_clk), .i_addr(o_bus_addr), .i_rd(o_bus_rd),
                        .i_wr(o_bus_wr), .i_wdata(o_bus_wdata), .o_rdata(i_bus_rdata));
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      if (o_sp_load) sp_seen <= o_sp_new;
      if (o_set_imask) im_seen <= 1'b1;
      if (o_clr_imask) clr_seen <= 1'b1;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task tick(input int n = 1);
      repeat (n) begin @(posedge i_clk); #1; end
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task await_seq;
      for (int k = 0; k < 30 && o_seq_done !== 1'b1; k++) tick();
      chk(o_seq_done, 1);
   endtask
   task ea_go(input logic [3:0] m);
      i_ea_mode = m; i_ea_req = 1; tick(); i_ea_req = 0;
      for (int k = 0; k < 10 && o_ea_done !== 1'b1; k++) tick();
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      int n;
      n = 0;
      for (int k = 0; k < 10 && o_bus_rd !== 1'b1; k++) tick();
      chk(o_bus_addr, 16'hFFFE);
      while (o_seq_done !== 1'b1 && n < 20) begin tick(); n++; end
      chk(n[15:0], 16'h0006);
      chk(o_pc_new, 16'h4003);
      $display("end reset");
   endtask
   task t_ea;
      logic [15:0] want [9];
      want = '{16'h0080, 16'h8040, 16'hFFC0, 16'hFFC0, 16'h0040, 16'h0040, 16'h8000,
               16'h0280, 16'h8240};
      i_hx = 16'hFFC0; i_sp = 16'h0200; i_op_compare_branch_if_equal = 1;
      for (int m = 0; m < 9; m++) begin
         ea_go(m[3:0]);
         chk(o_ea_addr, want[m]);
         chk(o_operand, u_mem.mem[want[m]]);
         chk({15'h0, o_hx_load}, {15'h0, m == 3 || m == 5});
         if (m == 3 || m == 5) chk(o_hx_new, 16'hFFC1);
         tick();
      end
      i_hx = 16'hFFFF; i_op_compare_branch_if_equal = 0; i_op_move = 1;
      ea_go(4'h3); chk(o_hx_new, 16'h0000); chk(o_ea_fault, 0);
      tick(); ea_go(4'h5); chk(o_ea_fault, 1);
      i_op_move = 0; tick();
      $display("end ea");
   endtask
   task t_soft;
      i_pc = 16'h1234; i_hx = 16'hABCD; i_a = 8'h5A; i_cond_codes = 8'h08; i_sp = 16'h0300;
      u_mem.mem[16'h02FB] = 8'hEE; sp_seen = 0; im_seen = 0;
      i_soft_int = 1; tick(); i_soft_int = 0; await_seq();
      chk(o_pc_new, 16'h2003);
      chk({u_mem.mem[16'h0300], u_mem.mem[16'h02FF]}, 16'h3412);
      chk({u_mem.mem[16'h02FE], u_mem.mem[16'h02FD]}, 16'hCD5A);
      chk({u_mem.mem[16'h02FC], u_mem.mem[16'h02FB]}, 16'h08EE);
      chk(sp_seen, 16'h02FB); chk(im_seen, 1);
      $display("end soft interrupt");
   endtask
   task t_irq;
      i_irq_pend = 8'h06; i_boundary = 1; tick(4);
      chk(o_busy, 0);
      i_cond_codes = 8'h00; await_seq(); i_irq_pend = 0; i_boundary = 0;
      chk(o_pc_new, 16'h3003);
      $display("end irq");
   endtask
   task t_abort;
      i_soft_int = 1; tick(); i_soft_int = 0; tick(2);
      i_reset_event = 1; tick(2);
      chk(o_bus_wr, 0); chk(o_busy, 1);
      i_reset_event = 0; await_seq(); chk(o_pc_new, 16'h4003);
      $display("end abort");
   endtask
   task t_lowpow;
      clr_seen = 0; i_wait = 1; tick(); i_wait = 0; tick(2);
      chk(o_cpu_clk_en, 0); chk(clr_seen, 1);
      i_irq_pend = 8'h01; tick(2); i_irq_pend = 0; chk(o_cpu_clk_en, 1);
      i_wait = 1; tick(); i_wait = 0; tick(); i_dbg_cmd = 1; tick(); i_dbg_cmd = 0; tick();
      chk(o_in_bdm, 1); chk(o_cpu_clk_en, 1);
      i_dbg_resume = 1; tick(); i_dbg_resume = 0; tick(); chk(o_in_bdm, 0);
      i_stop = 1; tick(); i_stop = 0; tick(); chk(o_osc_keep, 0);
      i_stop_wake = 1; tick(2); i_stop_wake = 0; chk(o_cpu_clk_en, 1);
      i_dbg_enable = 1; i_stop = 1; tick(); i_stop = 0; tick(); chk(o_osc_keep, 1);
      i_dbg_cmd = 1; tick(); i_dbg_cmd = 0; tick(); chk(o_in_bdm, 1);
      i_dbg_resume = 1; tick(); i_dbg_resume = 0; tick();
      i_brk_dbg = 1; tick(); i_brk_dbg = 0; i_soft_int = 1; tick(); i_soft_int = 0; tick(2);
      chk(o_in_bdm, 1); chk(o_busy, 1);
      i_dbg_resume = 1; tick(); i_dbg_resume = 0; tick(); chk(o_in_bdm, 0);
      $display("end lowpow");
   endtask
   // ------------------------------------------------------------
   // sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      #1;
      u_mem.mem[16'hFFFE] = 8'h40; u_mem.mem[16'hFFFF] = 8'h00;
      u_mem.mem[16'hFFFC] = 8'h20; u_mem.mem[16'hFFFD] = 8'h00;
      u_mem.mem[16'hFFF8] = 8'h30; u_mem.mem[16'hFFF9] = 8'h00;
      u_mem.mem[16'h1000] = 8'h80; u_mem.mem[16'h1001] = 8'h40;
      repeat (8) @(posedge i_clk);
      #1 i_rst_b = 1;
      t_reset(); t_ea(); t_soft(); t_irq(); t_abort(); t_lowpow();
      close_out();
   end
   initial begin
      #50000;
      mismatches++;
      close_out();
   end
endmodule // tb
